// file: pkg/fault_safety_pkg.sv
// Constants for the position sensor fault monitor and safety output.
// Assumes a 10 MHz system clock; all counts derive from it.
package fault_safety_pkg;

    // Clock
    localparam int CLK_HZ = 10_000_000;

    // Delay between a frame and its inverted copy
    localparam int INV_SHIFT_US = 10;
    localparam int INV_SHIFT_CYC = (INV_SHIFT_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                   INV_SHIFT_US * (CLK_HZ / 1_000_000);
    localparam int SHIFT_W = 8;

    // Over-temperature limit in degrees C
    localparam logic [7:0] TEMP_LIMIT_C = 8'h64;

    // Frame layout: position, velocity, status, counter
    localparam int POS_W = 32;
    localparam int VEL_W = 16;
    localparam int STAT_W = 8;
    localparam int CNT_W = 8;
    localparam int FRAME_W = POS_W + VEL_W + STAT_W + CNT_W;

    // Status byte bits
    localparam int ST_MAGNET = 0;
    localparam int ST_HW = 1;
    localparam int ST_PARAM_CRC = 2;
    localparam int ST_RANGE = 3;
    localparam int ST_TEMP = 4;
    localparam int ST_PROG_CRC = 5;
    localparam int ST_TERMINAL = 6;

    // Message kinds queued for the link
    localparam int KIND_W = 2;
    localparam logic [1:0] KIND_NORMAL = 2'h0;
    localparam logic [1:0] KIND_INVERTED = 2'h1;
    localparam logic [1:0] KIND_EMCY = 2'h2;

    // Transmit queue
    localparam int FIFO_W = FRAME_W + KIND_W;
    localparam int FIFO_DEPTH = 8;

    // Analog output codes (full scale 16 bit)
    localparam int ANA_W = 16;
    localparam logic [15:0] ANA_FAIL_LO = 16'h0000;
    localparam logic [15:0] ANA_FAIL_HI = 16'hFFFF;
    localparam logic [15:0] ANA_VALID_MIN = 16'h1000;
    localparam logic [15:0] ANA_VALID_MAX = 16'hE000;

    // Parameter protection
    localparam int PARAM_W = 16;
    localparam logic [15:0] PARAM_UNLOCK_KEY = 16'hA5C3;
    localparam logic [15:0] PARAM_RESET = 16'h0000;

    // Reset values
    localparam logic [7:0] CNT_RESET = 8'h00;

endpackage : fault_safety_pkg

// file: src/frame_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, clock enable freezes it.
`timescale 1ns/1ps
module frame_fifo #(
    parameter int WIDTH = 66,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg, wr_ptr_next;
    logic [AW:0] rd_ptr_reg, rd_ptr_next;
    logic do_wr, do_rd;

    assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) ||
                      (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (do_wr) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
        end
        if (do_rd) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (clk_en) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en && do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

endmodule : frame_fifo

// file: src/position_fault_safety_output.sv
// Fault monitor and safety output of a linear position sensor: analog
// failure bands, or CAN frames with inverted copies and emergencies.
// Assumes all inputs synchronous to clk; the link drains tx_* by ready.
//
// Operation
// - Diagnostics run always; any fault forces the fail-safe output state.
// - Analog faults: magnet, hardware, parameter checksum, range, program checksum.
// - Analog failure shown as high level above or low level below range.
// - Magnet beyond stroke drives the analog output to the low level.
// - Missing magnet drives the analog output to the low level.
// - Frame holds position 4 bytes, velocity 2, status 1, counter 1.
// - Each frame is followed later by a fully bit-inverted copy.
// - Counter advances per frame and per emergency, not per inverted copy, and rides in both copies.
// - Magnet and hardware faults raise an emergency message.
// - Parameter checksum and range faults appear in frame status.
// - Temperature above 100 C appears as fault in frame status.
// - Safety parameter changes need a prior correct unlock key.
// - Recoverable faults clear as soon as the condition goes away.
// - Terminal faults hold the failure output until reset.
`timescale 1ns/1ps
module position_fault_safety_output
    import fault_safety_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Variant strap: high selects the CAN link, low the analog output
    input wire logic can_variant,
    // Diagnostic inputs
    input wire logic magnet_missing,
    input wire logic hw_failure,
    input wire logic param_crc_bad,
    input wire logic prog_crc_bad,
    input wire logic out_of_range,
    input wire logic [7:0] temp_c,
    // Measurement
    input wire logic sample_valid,
    input wire logic [fault_safety_pkg::POS_W-1:0] position,
    input wire logic [fault_safety_pkg::VEL_W-1:0] velocity,
    // Safety parameter port
    input wire logic param_key_wr,
    input wire logic [fault_safety_pkg::PARAM_W-1:0] param_key,
    input wire logic param_wr,
    input wire logic [fault_safety_pkg::PARAM_W-1:0] param_data,
    output logic [fault_safety_pkg::PARAM_W-1:0] safety_param,
    output logic param_unlocked,
    output logic param_refused,
    // Analog output
    output logic [fault_safety_pkg::ANA_W-1:0] analog_code,
    // Status
    output logic fail_safe,
    output logic terminal_fault,
    output logic variant_is_can,
    // CAN transmit queue
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [fault_safety_pkg::FRAME_W-1:0] tx_data,
    output logic [fault_safety_pkg::KIND_W-1:0] tx_kind
);
    import fault_safety_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE,
        S_NORM,
        S_SHIFT,
        S_INV
    } tx_state_e;

    // Variant strap capture
    logic started_reg, started_next;
    logic can_reg, can_next;

    // Fault state
    logic terminal_reg, terminal_next;
    logic fail_reg, fail_next;
    logic [STAT_W-1:0] status_now;
    logic overtemp;
    logic fault_analog, fault_can;

    // Analog output
    logic [ANA_W-1:0] ana_reg, ana_next;

    // Transmit sequencer
    tx_state_e state_reg, state_next;
    logic [FRAME_W-1:0] frame_reg, frame_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [SHIFT_W-1:0] shift_reg, shift_next;
    logic emcy_pend_reg, emcy_pend_next;
    logic emcy_src_reg, emcy_src_next;
    logic emcy_event;
    logic q_valid, q_ready;
    logic [FIFO_W-1:0] q_data;
    logic [FIFO_W-1:0] q_out;

    // Parameter protection
    logic [PARAM_W-1:0] param_reg, param_next;
    logic unlock_reg, unlock_next;
    logic refused_reg, refused_next;

    assign overtemp = (temp_c > TEMP_LIMIT_C);

    always_comb begin
        status_now = '0;
        status_now[ST_MAGNET] = magnet_missing;
        status_now[ST_HW] = hw_failure;
        status_now[ST_PARAM_CRC] = param_crc_bad;
        status_now[ST_RANGE] = out_of_range;
        status_now[ST_TEMP] = overtemp;
        status_now[ST_PROG_CRC] = prog_crc_bad;
        status_now[ST_TERMINAL] = terminal_reg;
    end

    // Recoverable faults follow their inputs; terminal ones stay latched
    // Terminal inputs count at once, before the latch has caught them
    assign fault_analog = magnet_missing | param_crc_bad | out_of_range
                          | hw_failure | prog_crc_bad | terminal_reg;
    assign fault_can = fault_analog | overtemp;

    // Strap, terminal latch and fail-safe flag
    always_comb begin
        started_next = 1'b1;
        can_next = can_reg;
        if (!started_reg) begin
            can_next = can_variant;
        end
        terminal_next = terminal_reg | hw_failure | prog_crc_bad;
        fail_next = can_reg ? fault_can : fault_analog;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            started_reg <= 1'b0;
            can_reg <= 1'b0;
            terminal_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else if (clk_en) begin
            started_reg <= started_next;
            can_reg <= can_next;
            terminal_reg <= terminal_next;
            fail_reg <= fail_next;
        end
    end

    // Analog output: low band for magnet and range faults, high band for other faults, else position clamped to valid range
    always_comb begin
        ana_next = ana_reg;
        if (magnet_missing || out_of_range) begin
            ana_next = ANA_FAIL_LO;
        end else if (fault_analog) begin
            ana_next = ANA_FAIL_HI;
        end else if (position[ANA_W-1:0] < ANA_VALID_MIN) begin
            ana_next = ANA_VALID_MIN;
        end else if (position[ANA_W-1:0] > ANA_VALID_MAX) begin
            ana_next = ANA_VALID_MAX;
        end else begin
            ana_next = position[ANA_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_reg <= ANA_FAIL_LO;
        end else if (clk_en) begin
            ana_reg <= ana_next;
        end
    end

    // Emergency on a rising magnet or hardware fault
    assign emcy_event = (magnet_missing | hw_failure) & ~emcy_src_reg & can_reg;

    // Transmit sequencer
    always_comb begin
        state_next = state_reg;
        frame_next = frame_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        emcy_src_next = magnet_missing | hw_failure;
        emcy_pend_next = emcy_pend_reg;
        q_valid = 1'b0;
        q_data = {KIND_NORMAL, frame_reg};
        unique case (state_reg)
            S_IDLE: begin
                if (emcy_pend_reg) begin
                    q_valid = 1'b1;
                    q_data = {KIND_EMCY, {(FRAME_W-STAT_W-CNT_W){1'b0}}, status_now, cnt_reg};
                    if (q_ready) begin
                        emcy_pend_next = 1'b0;
                        cnt_next = cnt_reg + 1'b1;
                    end
                end else if (sample_valid && can_reg) begin
                    frame_next = {position, velocity, status_now, cnt_reg};
                    state_next = S_NORM;
                end
            end
            S_NORM: begin
                q_valid = 1'b1;
                q_data = {KIND_NORMAL, frame_reg};
                if (q_ready) begin
                    cnt_next = cnt_reg + 1'b1;
                    shift_next = '0;
                    state_next = S_SHIFT;
                end
            end
            S_SHIFT: begin
                shift_next = shift_reg + 1'b1;
                if (shift_reg == SHIFT_W'(INV_SHIFT_CYC - 1)) begin
                    state_next = S_INV;
                end
            end
            S_INV: begin
                q_valid = 1'b1;
                q_data = {KIND_INVERTED, ~frame_reg};
                if (q_ready) begin
                    state_next = S_IDLE;
                end
            end
        endcase
        // A new event outranks the clear of the pending flag
        if (emcy_event) begin
            emcy_pend_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            frame_reg <= '0;
            cnt_reg <= CNT_RESET;
            shift_reg <= '0;
            emcy_pend_reg <= 1'b0;
            emcy_src_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            frame_reg <= frame_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            emcy_pend_reg <= emcy_pend_next;
            emcy_src_reg <= emcy_src_next;
        end
    end

    frame_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(q_valid),
        .in_ready(q_ready),
        .in_data(q_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(q_out)
    );

    // Parameter write protection: key opens one write
    always_comb begin
        param_next = param_reg;
        unlock_next = unlock_reg;
        refused_next = 1'b0;
        if (param_wr) begin
            if (unlock_reg) begin
                param_next = param_data;
            end else begin
                refused_next = 1'b1;
            end
            unlock_next = 1'b0;
        end else if (param_key_wr) begin
            unlock_next = (param_key == PARAM_UNLOCK_KEY);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            param_reg <= PARAM_RESET;
            unlock_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else if (clk_en) begin
            param_reg <= param_next;
            unlock_reg <= unlock_next;
            refused_reg <= refused_next;
        end
    end

    assign tx_data = q_out[FRAME_W-1:0];
    assign tx_kind = q_out[FIFO_W-1:FRAME_W];
    assign analog_code = ana_reg;
    assign fail_safe = fail_reg;
    assign terminal_fault = terminal_reg;
    assign variant_is_can = can_reg;
    assign safety_param = param_reg;
    assign param_unlocked = unlock_reg;
    assign param_refused = refused_reg;

endmodule : position_fault_safety_output

// file: test/position_fault_safety_output_asserts.sv
// Checker for the fault monitor and safety output, bound to its top.
// Assumes it sees only the top's ports; helper flops track link words.
`timescale 1ns/1ps
module position_fault_safety_output_asserts
    import fault_safety_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Diagnostics
    input wire logic magnet_missing,
    input wire logic hw_failure,
    input wire logic param_crc_bad,
    input wire logic prog_crc_bad,
    input wire logic out_of_range,
    // Parameter port
    input wire logic param_wr,
    input wire logic [fault_safety_pkg::PARAM_W-1:0] safety_param,
    input wire logic param_unlocked,
    input wire logic param_refused,
    // Outputs
    input wire logic [fault_safety_pkg::ANA_W-1:0] analog_code,
    input wire logic fail_safe,
    input wire logic terminal_fault,
    input wire logic variant_is_can,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [fault_safety_pkg::FRAME_W-1:0] tx_data,
    input wire logic [fault_safety_pkg::KIND_W-1:0] tx_kind
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [FRAME_W-1:0] norm_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic seen_reg;
    logic take;
    assign take = tx_valid && tx_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            norm_reg <= '0;
            cnt_reg <= CNT_RESET;
            seen_reg <= 1'b0;
        end else if (take && tx_kind != KIND_INVERTED) begin
            norm_reg <= (tx_kind == KIND_NORMAL) ? tx_data : norm_reg;
            cnt_reg <= tx_data[7:0];
            seen_reg <= 1'b1;
        end
    end
    property p_magnet_low;
        clk_en && magnet_missing && !variant_is_can |=> fail_safe && analog_code == ANA_FAIL_LO;
    endproperty
    a_magnet_low: assert property (p_magnet_low) else $error("magnet fault not low");
    property p_range_low;
        clk_en && out_of_range && !variant_is_can |=> analog_code == ANA_FAIL_LO;
    endproperty
    a_range_low: assert property (p_range_low) else $error("range fault not low");
    property p_other_high;
        clk_en && param_crc_bad && !magnet_missing && !out_of_range && !variant_is_can
            |=> fail_safe && analog_code == ANA_FAIL_HI;
    endproperty
    a_other_high: assert property (p_other_high) else $error("checksum fault not high");
    property p_terminal;
        clk_en && hw_failure |=> terminal_fault [*8];
    endproperty
    a_terminal: assert property (p_terminal) else $error("terminal fault not held");
    property p_recover;
        clk_en && !variant_is_can && !terminal_fault && !(magnet_missing || hw_failure
            || param_crc_bad || prog_crc_bad || out_of_range) |=> !fail_safe;
    endproperty
    a_recover: assert property (p_recover) else $error("fault did not clear");
    property p_refuse;
        clk_en && param_wr && !param_unlocked |=> param_refused && $stable(safety_param);
    endproperty
    a_refuse: assert property (p_refuse) else $error("locked write not refused");
    property p_inverted;
        take && tx_kind == KIND_INVERTED |-> tx_data == ~norm_reg;
    endproperty
    a_inverted: assert property (p_inverted) else $error("copy not inverse");
    property p_counter;
        take && tx_kind != KIND_INVERTED && seen_reg |-> tx_data[7:0] == cnt_reg + 8'h01;
    endproperty
    a_counter: assert property (p_counter) else $error("counter gap");
    property p_emcy;
        take && tx_kind == KIND_EMCY |-> tx_data[FRAME_W-1:16] == '0;
    endproperty
    a_emcy: assert property (p_emcy) else $error("emergency word malformed");
endmodule : position_fault_safety_output_asserts

bind position_fault_safety_output position_fault_safety_output_asserts chk_u (.clk, .rst_n,
    .clk_en, .magnet_missing, .hw_failure, .param_crc_bad, .prog_crc_bad, .out_of_range,
    .param_wr, .safety_param, .param_unlocked, .param_refused, .analog_code, .fail_safe,
    .terminal_fault, .variant_is_can, .tx_valid, .tx_ready, .tx_data, .tx_kind);

// file: test/link_controller_model.sv
// Machine controller model: drains the link and cross-checks copies.
// Assumes the bench drives stall; taken words are kept for the bench.
`timescale 1ns/1ps
module link_controller_model
    import fault_safety_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic stall,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [fault_safety_pkg::FRAME_W-1:0] tx_data,
    input wire logic [fault_safety_pkg::KIND_W-1:0] tx_kind,
    // Analog output
    input wire logic [fault_safety_pkg::ANA_W-1:0] analog_code
);
    logic [FRAME_W+KIND_W-1:0] got[$];
    logic [FRAME_W-1:0] last = '0;
    int bad = 0;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
            got.delete();
        end else begin
            tx_ready <= !stall;
            if (tx_valid && tx_ready) begin
                got.push_back({tx_kind, tx_data});
                if (tx_kind == KIND_NORMAL) last = tx_data;
                if (tx_kind == KIND_INVERTED && tx_data !== ~last) bad++;
            end
        end
    end
    // Reading counts as valid only after 10 ms straight in the window
    localparam int QUAL_CYC = 10 * (CLK_HZ / 1000);
    int qual_cnt;
    logic ana_ok;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qual_cnt <= 0;
        end else if (analog_code < ANA_VALID_MIN || analog_code > ANA_VALID_MAX) begin
            qual_cnt <= 0;
        end else if (qual_cnt < QUAL_CYC) begin
            qual_cnt <= qual_cnt + 1;
        end
    end
    assign ana_ok = (qual_cnt == QUAL_CYC);
endmodule : link_controller_model

// file: test/position_fault_safety_output_bench.sv
// Bench: analog fault codes, parameter lock, CAN frames and emergencies.
// Assumes the controller model drains the link queue.
`timescale 1ns/1ps
module position_fault_safety_output_bench;
    import fault_safety_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, can_variant = 1'b0, stall = 1'b0;
    logic sample_valid = 1'b0, param_key_wr = 1'b0, param_wr = 1'b0;
    logic [4:0] flt = '0;
    logic [7:0] temp_c = 8'h19;
    logic [POS_W-1:0] position = '0;
    logic [VEL_W-1:0] velocity = '0;
    logic [PARAM_W-1:0] param_key = '0, param_data = '0, safety_param;
    logic [ANA_W-1:0] analog_code;
    logic [FRAME_W-1:0] tx_data, w;
    logic [KIND_W-1:0] tx_kind;
    logic param_unlocked, param_refused, fail_safe, terminal_fault, variant_is_can;
    logic tx_valid, tx_ready;
    int err_count = 0, checks_done = 0;
    // Fault bits: 0 magnet, 1 hardware, 2 param checksum, 3 range, 4 program checksum
    localparam logic [4:0] FL [5] = '{5'h01, 5'h00, 5'h08, 5'h04, 5'h00};
    localparam logic [16:0] EX [5] = '{17'h10000, 17'h01000, 17'h10000, 17'h1FFFF, 17'h01000};
    always #50 clk = ~clk;
    position_fault_safety_output dut_u (.clk, .rst_n, .clk_en(1'b1), .can_variant,
        .magnet_missing(flt[0]), .hw_failure(flt[1]), .param_crc_bad(flt[2]),
        .out_of_range(flt[3]), .prog_crc_bad(flt[4]), .temp_c, .sample_valid, .position,
        .velocity, .param_key_wr, .param_key, .param_wr, .param_data, .safety_param,
        .param_unlocked, .param_refused, .analog_code, .fail_safe, .terminal_fault,
        .variant_is_can, .tx_valid, .tx_ready, .tx_data, .tx_kind);
    link_controller_model model_u (.clk, .rst_n, .stall, .tx_valid, .tx_ready, .tx_data,
        .tx_kind, .analog_code);
    task automatic chk(input logic [FRAME_W+KIND_W-1:0] seen,
                       input logic [FRAME_W+KIND_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic do_reset(input logic can);
        @(posedge clk);
        rst_n <= 1'b0;
        can_variant <= can;
        cyc(16);
        @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
    endtask : do_reset
    task automatic set_flt(input logic [4:0] f);
        @(posedge clk);
        flt <= f;
    endtask : set_flt
    task automatic sample(input logic [31:0] p, input logic [15:0] v);
        @(posedge clk);
        sample_valid <= 1'b1;
        position <= p;
        velocity <= v;
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask : sample
    task automatic key_wr(input logic [15:0] k, input logic [15:0] d);
        @(posedge clk);
        param_key_wr <= 1'b1;
        param_key <= k;
        @(posedge clk);
        param_key_wr <= 1'b0;
        param_wr <= 1'b1;
        param_data <= d;
        @(posedge clk);
        param_wr <= 1'b0;
        #1;
    endtask : key_wr
    task automatic wait_words(input int n);
        for (int i = 0; i < 400 && model_u.got.size() < n; i++) @(posedge clk);
        #1;
        chk(model_u.got.size(), n);
    endtask : wait_words
    task automatic t_analog;
        sample(32'h0000_0500, 16'h0000);
        cyc(2);
        chk(analog_code, ANA_VALID_MIN);
        for (int i = 0; i < 5; i++) begin
            set_flt(FL[i]);
            cyc(2);
            chk({fail_safe, analog_code}, EX[i]);
            if (i == 1) begin
                chk({model_u.ana_ok, 8'(model_u.qual_cnt)}, 9'h001);
            end
        end
        set_flt(5'h02);
        set_flt(5'h00);
        cyc(3);
        chk({terminal_fault, fail_safe, analog_code}, {2'b11, ANA_FAIL_HI});
    endtask : t_analog
    task automatic t_param;
        key_wr(16'h1234, 16'h5A5A);
        chk({param_refused, safety_param}, {1'b1, PARAM_RESET});
        key_wr(PARAM_UNLOCK_KEY, 16'h5A5A);
        chk({param_unlocked, safety_param}, {1'b0, 16'h5A5A});
    endtask : t_param
    task automatic t_can;
        do_reset(1'b1);
        @(posedge clk);
        stall <= 1'b1;
        sample(32'h1234_5678, 16'hBEEF);
        cyc(150);
        chk({tx_valid, tx_kind, 8'(model_u.got.size())}, {1'b1, KIND_NORMAL, 8'h00});
        stall <= 1'b0;
        wait_words(2);
        w = model_u.got[0][63:0];
        chk(model_u.got[0][65:8], {KIND_NORMAL, 32'h1234_5678, 16'hBEEF, 8'h00});
        chk(model_u.got[1], {KIND_INVERTED, ~w});
        set_flt(5'h0C);
        temp_c <= 8'h65;
        sample(32'h0000_0042, 16'h0007);
        wait_words(4);
        chk(model_u.got[2][15:0], {8'h1C, 8'(w[7:0] + 8'h01)});
        set_flt(5'h00);
        temp_c <= 8'h19;
        cyc(5);
        set_flt(5'h01);
        wait_words(5);
        chk(model_u.got[4][65:64], KIND_EMCY);
        chk(model_u.got[4][7:0], 8'(w[7:0] + 8'h02));
        chk(model_u.bad, 0);
        set_flt(5'h10);
        cyc(2);
        chk({terminal_fault, fail_safe, variant_is_can}, 3'b111);
    endtask : t_can
    initial begin
        do_reset(1'b0);
        t_analog;
        t_param;
        t_can;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run;
    end
endmodule : position_fault_safety_output_bench
